// *** hw/bsc_top.v ***
// pin scan chain with test access controller sampled on the system clock
`timescale 1ns/1ps
`include "bsc_regs.vh"

module bsc_top #(
  parameter N_HPIN = `BSC_HPIN_NUM,
  parameter [0:0] CTRL_ACTIVE = `BSC_CTRL_ACTIVE,
  parameter [31:0] ID_VALUE = `BSC_ID_VALUE
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // test port pins
  input wire i_tck,
  input wire i_tms,
  input wire i_tdi,
  input wire i_trst_b,
  output wire o_tdo,
  output wire o_tdo_oe,
  // pad inputs
  input wire [3:0] i_op_mode_pin,
  input wire [23:0] i_data_pad,
  input wire i_crystal_clock_in,
  input wire i_hw_reset_pad,
  input wire [N_HPIN-1:0] i_hpin_pad,
  // core side
  input wire [23:0] i_core_data,
  input wire i_core_data_oe_hi,
  input wire i_core_data_oe_lo,
  input wire [15:0] i_core_addr,
  input wire [4:0] i_core_strb,
  input wire [N_HPIN-1:0] i_core_hpin,
  input wire [N_HPIN-1:0] i_core_hpin_oe,
  input wire i_stop_req,
  input wire [1:0] i_emulation_status_bits,
  // pad drives
  output wire [23:0] o_data_pad,
  output wire o_data_oe_hi,
  output wire o_data_oe_lo,
  output wire [15:0] o_addr_pad,
  output wire o_addr_oe,
  output wire [4:0] o_strb_pad,
  output wire o_strb_oe,
  output wire [N_HPIN-1:0] o_hpin_pad,
  output wire [N_HPIN-1:0] o_hpin_oe,
  // system control
  output wire o_core_rst,
  output wire o_lowpower
);

  localparam CHAIN = `BSC_HPIN_CELL0 + 2 * N_HPIN;
  localparam PIN_W = 4 + 24 + 2 + N_HPIN;

  localparam [3:0] S_RESET = 4'h0;
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_SEL_DR = 4'h2;
  localparam [3:0] S_CAP_DR = 4'h3;
  localparam [3:0] S_SHF_DR = 4'h4;
  localparam [3:0] S_EX1_DR = 4'h5;
  localparam [3:0] S_PAU_DR = 4'h6;
  localparam [3:0] S_EX2_DR = 4'h7;
  localparam [3:0] S_UPD_DR = 4'h8;
  localparam [3:0] S_SEL_IR = 4'h9;
  localparam [3:0] S_CAP_IR = 4'ha;
  localparam [3:0] S_SHF_IR = 4'hb;
  localparam [3:0] S_EX1_IR = 4'hc;
  localparam [3:0] S_PAU_IR = 4'hd;
  localparam [3:0] S_EX2_IR = 4'he;
  localparam [3:0] S_UPD_IR = 4'hf;

  // data bit to cell, skipping the two enable cells
  function integer data_cell;
    input integer b;
    integer i;
    begin
      i = 23 - b;
      data_cell = i + 4 + ((i >= 9) ? 1 : 0) + ((i >= 21) ? 1 : 0);
    end
  endfunction

  // two-flop synchronisers for everything from the pins
  reg [3:0] jt_s1_q;
  reg [3:0] jt_s2_q;
  reg jt_tck_s3_q;
  reg [PIN_W-1:0] pin_s1_q;
  reg [PIN_W-1:0] pin_s2_q;

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      jt_s1_q <= 4'h0;
      jt_s2_q <= 4'h0;
      jt_tck_s3_q <= 1'b0;
      pin_s1_q <= {PIN_W{1'b0}};
      pin_s2_q <= {PIN_W{1'b0}};
    end else begin
      jt_s1_q <= {i_trst_b, i_tdi, i_tms, i_tck};
      jt_s2_q <= jt_s1_q;
      jt_tck_s3_q <= jt_s2_q[0];
      pin_s1_q <= {i_hpin_pad, i_hw_reset_pad, i_crystal_clock_in,
                   i_data_pad, i_op_mode_pin};
      pin_s2_q <= pin_s1_q;
    end
  end

  wire tck_s = jt_s2_q[0];
  wire tms_s = jt_s2_q[1];
  wire tdi_s = jt_s2_q[2];
  wire trst_b_s = jt_s2_q[3];
  wire tck_rise = tck_s & ~jt_tck_s3_q;
  wire tck_fall = ~tck_s & jt_tck_s3_q;

  reg [3:0] st_q;
  reg [3:0] st_d;
  reg [3:0] ir_sr_q;
  reg [3:0] ir_q;
  reg [CHAIN-1:0] bsr_sr_q;
  reg [CHAIN-1:0] bsr_upd_q;
  reg [31:0] id_sr_q;
  reg byp_q;
  reg tdo_q;
  reg tdo_oe_q;
  reg [CHAIN-1:0] cap;
  reg [23:0] data_pad_q;
  reg data_oe_hi_q;
  reg data_oe_lo_q;
  reg [15:0] addr_pad_q;
  reg pins_oe_q;
  reg [4:0] strb_pad_q;
  reg [N_HPIN-1:0] hpin_pad_q;
  reg [N_HPIN-1:0] hpin_oe_q;
  reg core_rst_q;
  reg lowpower_q;
  integer k;
  integer j;

  // mode-select high always walks toward reset within five edges
  always @* begin
    case (st_q)
      S_RESET: st_d = tms_s ? S_RESET : S_IDLE;
      S_IDLE: st_d = tms_s ? S_SEL_DR : S_IDLE;
      S_SEL_DR: st_d = tms_s ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: st_d = tms_s ? S_EX1_DR : S_SHF_DR;
      S_SHF_DR: st_d = tms_s ? S_EX1_DR : S_SHF_DR;
      S_EX1_DR: st_d = tms_s ? S_UPD_DR : S_PAU_DR;
      S_PAU_DR: st_d = tms_s ? S_EX2_DR : S_PAU_DR;
      S_EX2_DR: st_d = tms_s ? S_UPD_DR : S_SHF_DR;
      S_UPD_DR: st_d = tms_s ? S_SEL_DR : S_IDLE;
      S_SEL_IR: st_d = tms_s ? S_RESET : S_CAP_IR;
      S_CAP_IR: st_d = tms_s ? S_EX1_IR : S_SHF_IR;
      S_SHF_IR: st_d = tms_s ? S_EX1_IR : S_SHF_IR;
      S_EX1_IR: st_d = tms_s ? S_UPD_IR : S_PAU_IR;
      S_PAU_IR: st_d = tms_s ? S_EX2_IR : S_PAU_IR;
      S_EX2_IR: st_d = tms_s ? S_UPD_IR : S_SHF_IR;
      S_UPD_IR: st_d = tms_s ? S_SEL_DR : S_IDLE;
      default: st_d = S_RESET;
    endcase
  end

  wire sel_chain = (ir_q == `BSC_IR_EXTEST) || (ir_q == `BSC_IR_SAMPLE);
  wire sel_id = (ir_q == `BSC_IR_IDCODE);
  wire drive_test = (ir_q == `BSC_IR_EXTEST) || (ir_q == `BSC_IR_CLAMP);
  wire hiz = (ir_q == `BSC_IR_HIZ);
  wire dr_out = sel_chain ? bsr_sr_q[0] : (sel_id ? id_sr_q[0] : byp_q);

  // capture vector: what each pin shows now, outputs as driven
  always @* begin
    cap = {CHAIN{1'b0}};
    for (k = 0; k < 4; k = k + 1)
      cap[`BSC_MODE_CELL0 + k] = pin_s2_q[k];
    for (k = 0; k < 24; k = k + 1)
      cap[data_cell(k)] = pin_s2_q[4 + k];
    cap[`BSC_DHI_CTRL_CELL] = ~(data_oe_hi_q ^ CTRL_ACTIVE);
    cap[`BSC_DLO_CTRL_CELL] = ~(data_oe_lo_q ^ CTRL_ACTIVE);
    for (k = 0; k < 16; k = k + 1)
      cap[`BSC_ADDR_CELL0 + 15 - k] = addr_pad_q[k];
    for (k = 0; k < 5; k = k + 1)
      cap[`BSC_STRB_CELL0 + k] = strb_pad_q[k];
    cap[`BSC_XTAL_CELL] = pin_s2_q[28];
    cap[`BSC_HRST_CELL] = pin_s2_q[29];
    for (k = 0; k < N_HPIN; k = k + 1) begin
      cap[`BSC_HPIN_CELL0 + 2 * k] = ~(hpin_oe_q[k] ^ CTRL_ACTIVE);
      cap[`BSC_HPIN_CELL0 + 2 * k + 1] = pin_s2_q[30 + k];
    end
  end

  // controller runs on the free system clock, so stop mode never halts it
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= S_RESET;
      ir_sr_q <= 4'h0;
      ir_q <= `BSC_IR_IDCODE;
      bsr_sr_q <= {CHAIN{1'b0}};
      bsr_upd_q <= {CHAIN{1'b0}};
      id_sr_q <= 32'h0;
      byp_q <= 1'b0;
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (!trst_b_s) begin
      st_q <= S_RESET;
      ir_q <= `BSC_IR_IDCODE;
      tdo_oe_q <= 1'b0;
    end else begin
      if (tck_rise) begin
        st_q <= st_d;
        case (st_q)
          S_CAP_IR: ir_sr_q <= {2'b00, i_emulation_status_bits};
          S_SHF_IR: ir_sr_q <= {tdi_s, ir_sr_q[3:1]};
          S_CAP_DR: begin
            if (sel_chain)
              bsr_sr_q <= cap;
            id_sr_q <= ID_VALUE;
            byp_q <= 1'b0;
          end
          S_SHF_DR: begin
            if (sel_chain)
              bsr_sr_q <= {tdi_s, bsr_sr_q[CHAIN-1:1]};
            if (sel_id)
              id_sr_q <= {tdi_s, id_sr_q[31:1]};
            byp_q <= tdi_s;
          end
          default: ;
        endcase
      end
      if (tck_fall) begin
        tdo_q <= (st_q == S_SHF_IR) ? ir_sr_q[0] : dr_out;
        tdo_oe_q <= (st_q == S_SHF_IR) || (st_q == S_SHF_DR);
        if (st_q == S_RESET)
          ir_q <= `BSC_IR_IDCODE;
        if (st_q == S_UPD_IR)
          ir_q <= ir_sr_q;
        // preload under sample too, pins untouched until external test or clamp
        if (st_q == S_UPD_DR && sel_chain)
          bsr_upd_q <= bsr_sr_q;
      end
    end
  end

  // pad drive: core, scan update cells, or everything off
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      data_pad_q <= 24'h0;
      data_oe_hi_q <= 1'b0;
      data_oe_lo_q <= 1'b0;
      addr_pad_q <= 16'h0;
      pins_oe_q <= 1'b0;
      strb_pad_q <= 5'h0;
      hpin_pad_q <= {N_HPIN{1'b0}};
      hpin_oe_q <= {N_HPIN{1'b0}};
      core_rst_q <= 1'b0;
      lowpower_q <= 1'b0;
    end else begin
      core_rst_q <= drive_test && (ir_q == `BSC_IR_CLAMP) || hiz;
      // leaving test-logic reset costs the low power, nothing else
      lowpower_q <= i_stop_req && (st_q == S_RESET);
      pins_oe_q <= ~hiz;
      if (drive_test) begin
        for (j = 0; j < 24; j = j + 1)
          data_pad_q[j] <= bsr_upd_q[data_cell(j)];
        data_oe_hi_q <= ~(bsr_upd_q[`BSC_DHI_CTRL_CELL] ^ CTRL_ACTIVE);
        data_oe_lo_q <= ~(bsr_upd_q[`BSC_DLO_CTRL_CELL] ^ CTRL_ACTIVE);
        for (j = 0; j < 16; j = j + 1)
          addr_pad_q[j] <= bsr_upd_q[`BSC_ADDR_CELL0 + 15 - j];
        for (j = 0; j < 5; j = j + 1)
          strb_pad_q[j] <= bsr_upd_q[`BSC_STRB_CELL0 + j];
        for (j = 0; j < N_HPIN; j = j + 1) begin
          hpin_oe_q[j] <= ~(bsr_upd_q[`BSC_HPIN_CELL0 + 2 * j] ^
                            CTRL_ACTIVE);
          hpin_pad_q[j] <= bsr_upd_q[`BSC_HPIN_CELL0 + 2 * j + 1];
        end
      end else begin
        data_pad_q <= i_core_data;
        // hi-z gated here so every pad enable leaves a flop directly
        data_oe_hi_q <= i_core_data_oe_hi & ~hiz;
        data_oe_lo_q <= i_core_data_oe_lo & ~hiz;
        addr_pad_q <= i_core_addr;
        strb_pad_q <= i_core_strb;
        hpin_pad_q <= i_core_hpin;
        hpin_oe_q <= i_core_hpin_oe & {N_HPIN{~hiz}};
      end
    end
  end

  assign o_tdo = tdo_q;
  assign o_tdo_oe = tdo_oe_q;
  assign o_data_pad = data_pad_q;
  assign o_data_oe_hi = data_oe_hi_q;
  assign o_data_oe_lo = data_oe_lo_q;
  assign o_addr_pad = addr_pad_q;
  assign o_addr_oe = pins_oe_q;
  assign o_strb_pad = strb_pad_q;
  assign o_strb_oe = pins_oe_q;
  assign o_hpin_pad = hpin_pad_q;
  assign o_hpin_oe = hpin_oe_q;
  assign o_core_rst = core_rst_q;
  assign o_lowpower = lowpower_q;

endmodule // bsc_top

// *** inc/bsc_regs.vh ***
// constants for the pin scan chain and its test access controller
// Notes on behaviour
// - five consecutive rising test clocks with mode-select high force reset.
// - mode-select held high keeps the controller in its reset state.
// - low-power stop only while the controller sits in its reset state.
// - controller keeps advancing on test clock while core clocks stop.
// - status is readable through the instruction path during stop mode.
// - cells 0 to 3 capture the four operating-mode pins.
// - data bus uses two-way cells; cell 13 enables upper, 26 lower.
// - cells 30 to 45 drive address bits 15 down to 0.
// - cells 46 to 50 drive chip-select, read, write, tracking, clock out.
// - cells 51 and 52 capture crystal clock and hardware reset.
// - from cell 53 each two-way pin has control then data cell.
// - instruction capture loads emulation status; 11 means debug entered.
// - sample captures pins at data capture without disturbing them.
`ifndef BSC_REGS_VH
`define BSC_REGS_VH

`define BSC_IR_W 4
`define BSC_IR_EXTEST 4'h0
`define BSC_IR_SAMPLE 4'h1
`define BSC_IR_IDCODE 4'h2
`define BSC_IR_CLAMP 4'h3
`define BSC_IR_HIZ 4'h4
`define BSC_IR_BYPASS 4'hf

`define BSC_MODE_CELL0 0
`define BSC_DHI_CTRL_CELL 13
`define BSC_DLO_CTRL_CELL 26
`define BSC_DATA_W 24
`define BSC_ADDR_CELL0 30
`define BSC_ADDR_W 16
`define BSC_STRB_CELL0 46
`define BSC_STRB_W 5
`define BSC_XTAL_CELL 51
`define BSC_HRST_CELL 52
`define BSC_HPIN_CELL0 53
`define BSC_HPIN_NUM 36

// strobe bit positions within the strobe group
`define BSC_STRB_MEMORY_CHIP_SELECT 0
`define BSC_STRB_READ 1
`define BSC_STRB_WRITE 2
`define BSC_STRB_ADDR_TRACKING_OUT 3
`define BSC_STRB_CLOCK_OUTPUT_PIN 4

`define BSC_CTRL_ACTIVE 1'b1
// arbitrary identity value, lsb must be one
`define BSC_ID_VALUE 32'h00000001

`endif

// *** tb/bsc_tap_model.sv ***
// test controller model driving the test port pins
`timescale 1ns/1ps
module bsc_tap_model (
  // clock and test data from the device
  input wire i_clk,
  input wire i_tdo,
  // test port drives
  output reg o_tck,
  output reg o_tms,
  output reg o_tdi,
  output reg o_trst_b
);
  // tck stands low between frames; tms and tdi start high like their pull-ups
  // never issues external test, so no enables reach driven nets
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
    o_trst_b = 1'b0;
  end
  task half;
    begin
      repeat (10) @(posedge i_clk);
      #1;
    end
  endtask
  task power_up;
    begin
      half;
      o_trst_b = 1'b1;
      half;
    end
  endtask
  // one tck period; tdo taken just before the rising edge
  task bit_io(input t, input d, output q);
    begin
      o_tms = t;
      o_tdi = d;
      half;
      q = i_tdo;
      o_tck = 1'b1;
      half;
      o_tck = 1'b0;
    end
  endtask
  // from idle: one scan, lsb first, back to idle
  task scan(input ir, input integer n, input [127:0] din,
            output [127:0] dout);
    integer k;
    reg q;
    begin
      dout = 128'h0;
      bit_io(1'b1, 1'b1, q);
      if (ir) bit_io(1'b1, 1'b1, q);
      bit_io(1'b0, 1'b1, q);
      bit_io(1'b0, 1'b1, q);
      for (k = 0; k < n; k = k + 1) begin
        bit_io(k == n - 1, din[k], q);
        dout[k] = q;
      end
      bit_io(1'b1, 1'b1, q);
      bit_io(1'b0, 1'b1, q);
    end
  endtask
endmodule // bsc_tap_model

// *** tb/bsc_assertions.sv ***
// checker for the pin scan chain ports
`timescale 1ns/1ps
module bsc_assertions (
  // clock, reset and inputs
  input wire i_clk,
  input wire i_rst_b,
  input wire i_tck,
  input wire i_tms,
  input wire i_trst_b,
  input wire [15:0] i_core_addr,
  input wire i_core_data_oe_hi,
  input wire i_stop_req,
  // outputs
  input wire o_tdo,
  input wire o_tdo_oe,
  input wire [15:0] o_addr_pad,
  input wire o_data_oe_hi,
  input wire o_core_rst,
  input wire o_lowpower
);
  reg tck_q;
  reg [2:0] cnt_q;
  // counts raw pin edges; the design lags them, hence the past term below
  wire rst_ok = cnt_q >= 3'd5;
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tck_q <= 1'b0;
      cnt_q <= 3'd0;
    end else begin
      tck_q <= i_tck;
      if (!i_tms) cnt_q <= 3'd0;
      else if (i_tck && !tck_q && cnt_q != 3'd7) cnt_q <= cnt_q + 3'd1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  property p_lp_stop; o_lowpower |-> $past(i_stop_req); endproperty
  a_lp_stop: assert property (p_lp_stop)
    else $error("lowpower no stop");
  property p_lp_idle;
    rst_ok && $past(rst_ok, 6) && $past(i_stop_req) |-> o_lowpower;
  endproperty
  a_lp_idle: assert property (p_lp_idle) else $error("lowpower lost");
  property p_trst; !i_trst_b [*6] |-> !o_tdo_oe; endproperty
  a_trst: assert property (p_trst) else $error("oe in test reset");
  property p_oe_idle;
    rst_ok && $past(rst_ok, 6) |-> !o_tdo_oe && !o_core_rst;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("active in reset");
  property p_addr_core;
    rst_ok && $past(rst_ok, 6) |-> o_addr_pad == $past(i_core_addr);
  endproperty
  a_addr_core: assert property (p_addr_core) else $error("addr moved");
  property p_oe_core;
    rst_ok && $past(rst_ok, 6) |-> o_data_oe_hi == $past(i_core_data_oe_hi);
  endproperty
  a_oe_core: assert property (p_oe_core) else $error("oe moved");
  property p_tdo_fall; $changed(o_tdo) |-> !$past(i_tck, 2); endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo early");
  // enable rises only after a detected fall, so the pin was already low
  property p_oe_rise; $rose(o_tdo_oe) |-> !$past(i_tck); endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("oe off edge");
  c_lp: cover property (rst_ok && o_lowpower);
  c_oe: cover property ($rose(o_tdo_oe));
  c_lp_off: cover property ($fell(o_lowpower));
endmodule // bsc_assertions
bind bsc_top bsc_assertions bsc_assertions_i (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_tck(i_tck), .i_tms(i_tms),
  .i_trst_b(i_trst_b), .i_core_addr(i_core_addr),
  .i_core_data_oe_hi(i_core_data_oe_hi), .i_stop_req(i_stop_req),
  .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .o_addr_pad(o_addr_pad),
  .o_data_oe_hi(o_data_oe_hi), .o_core_rst(o_core_rst),
  .o_lowpower(o_lowpower));

// *** tb/bsc_top_tb.sv ***
// self-checking bench for the pin scan chain
`timescale 1ns/1ps
module bsc_top_tb;
  reg i_clk;
  reg i_rst_b;
  reg [3:0] op;
  reg [23:0] pad, cd;
  reg xt, hr, oeh, oel, stop;
  reg [35:0] hp, ch, cho;
  reg [15:0] ca;
  reg [4:0] sb;
  reg [1:0] st;
  wire tck, tms, tdi, trst_b, tdo, tdo_oe, crst, lp;
  wire [15:0] apad;
  wire [23:0] dpad;
  wire oeh_o, oel_o, aoe, soe;
  wire [4:0] spad;
  wire [35:0] hpad, hoe;
  integer err_total;
  integer total_checks;
  bsc_top bsc_top_i (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_tck(tck), .i_tms(tms),
    .i_tdi(tdi), .i_trst_b(trst_b), .o_tdo(tdo), .o_tdo_oe(tdo_oe),
    .i_op_mode_pin(op), .i_data_pad(pad), .i_crystal_clock_in(xt),
    .i_hw_reset_pad(hr), .i_hpin_pad(hp), .i_core_data(cd),
    .i_core_data_oe_hi(oeh), .i_core_data_oe_lo(oel), .i_core_addr(ca),
    .i_core_strb(sb), .i_core_hpin(ch), .i_core_hpin_oe(cho),
    .i_stop_req(stop), .i_emulation_status_bits(st), .o_data_pad(dpad),
    .o_data_oe_hi(oeh_o), .o_data_oe_lo(oel_o), .o_addr_pad(apad),
    .o_addr_oe(aoe), .o_strb_pad(spad), .o_strb_oe(soe),
    .o_hpin_pad(hpad), .o_hpin_oe(hoe),
    .o_core_rst(crst), .o_lowpower(lp));
  bsc_tap_model bsc_tap_model_i (.i_clk(i_clk), .i_tdo(tdo), .o_tck(tck),
    .o_tms(tms), .o_tdi(tdi), .o_trst_b(trst_b));
  task chk(input [127:0] got, input [127:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task t_status;
    reg [127:0] d;
    reg q;
    begin
      chk(lp, 1'b1);
      chk(crst, 1'b0);
      bsc_tap_model_i.bit_io(1'b0, 1'b1, q);
      chk(lp, 1'b0);
      bsc_tap_model_i.scan(1'b1, 4, 128'h1, d);
      chk(d[3:0], 4'h3);
    end
  endtask
  task t_sample;
    reg [127:0] d;
    integer k;
    begin
      {op, pad, xt, hr, cd} = {4'h9, 24'h81c3e4, 1'b1, 1'b0, 24'h3c5a69};
      {hp, cho, oeh, oel} = {36'hda5a5a5a5, 36'h3000000f1, 1'b1, 1'b0};
      {ca, sb, ch} = {16'hb2c5, 5'h15, 36'h0};
      bsc_tap_model_i.scan(1'b0, 125, 128'h0, d);
      chk(d[3:0], 4'h9);
      chk({d[29], d[4]}, 2'b01);
      chk({d[26], d[13]}, 2'b01);
      for (k = 0; k < 16; k = k + 1) chk(d[30 + k], ca[15 - k]);
      chk(d[50:46], 5'h15);
      chk(d[52:51], 2'b01);
      chk(d[54:53], 2'b11);
      chk(d[124:123], 2'b10);
      chk({apad, dpad}, {16'hb2c5, 24'h3c5a69});
      chk({oel_o, aoe, soe, spad}, {1'b0, 1'b1, 1'b1, 5'h15});
      chk({oeh_o, hpad, hoe}, {1'b1, 36'h0, 36'h3000000f1});
    end
  endtask
  task t_hiz;
    reg [127:0] d;
    reg q;
    begin
      bsc_tap_model_i.bit_io(1'b0, 1'b1, q);
      bsc_tap_model_i.scan(1'b1, 4, 128'h4, d);
      chk(d[3:0], 4'h3);
      chk({crst, oeh_o, aoe, soe, hoe}, {1'b1, 39'h0});
    end
  endtask
  task t_tms;
    reg q;
    integer k;
    begin
      bsc_tap_model_i.bit_io(1'b1, 1'b1, q);
      bsc_tap_model_i.bit_io(1'b0, 1'b1, q);
      bsc_tap_model_i.bit_io(1'b0, 1'b1, q);
      // from shift, four high rises must not yet reach reset
      for (k = 0; k < 4; k = k + 1) bsc_tap_model_i.bit_io(1'b1, 1'b1, q);
      chk(lp, 1'b0);
      ca = 16'h4e17;
      bsc_tap_model_i.bit_io(1'b1, 1'b1, q);
      chk(lp, 1'b1);
      for (k = 0; k < 4; k = k + 1) bsc_tap_model_i.bit_io(1'b1, 1'b1, q);
      chk({lp, tdo_oe, apad}, {2'b10, 16'h4e17});
      stop = 1'b0;
      repeat (3) @(posedge i_clk);
      #1;
      chk(lp, 1'b0);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  initial begin
    #200000;
    err_total = err_total + 1;
    finish_test;
  end
  initial begin
    err_total = 0;
    total_checks = 0;
    {op, pad, xt, hr, hp, cd, oeh, oel, ca, sb, ch, cho} = 0;
    stop = 1'b1;
    st = 2'b11;
    i_rst_b = 1'b0;
    repeat (20) @(posedge i_clk);
    #1;
    i_rst_b = 1'b1;
    bsc_tap_model_i.power_up;
    t_status;
    t_sample;
    t_tms;
    t_hiz;
    finish_test;
  end
endmodule // bsc_top_tb
